//--- pic_pkg.sv
package pic_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_INIT_ONE  = 3'h0;
    localparam logic [2:0] ADDR_INIT_FOUR = 3'h1;
    localparam logic [2:0] ADDR_MASK      = 3'h2;
    localparam logic [2:0] ADDR_OPW_TWO   = 3'h3;
    localparam logic [2:0] ADDR_OPW_THREE = 3'h4;
    localparam logic [2:0] ADDR_PENDING   = 3'h5;
    localparam logic [2:0] ADDR_INSERVICE = 3'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LEVEL_BIT    = 3;
    localparam int AUTO_END_OF_SERVICE_BIT     = 1;
    localparam int POLL_BIT     = 2;
    localparam int SMM_EN_BIT   = 6;
    localparam int SMM_VAL_BIT  = 5;
    localparam int PEND_FLAG_BIT = 7;

    // ------------------------------------------------------------
    // Operation word two commands, bits 7..5
    // ------------------------------------------------------------
    localparam logic [2:0] OP2_ROT_AUTO_END_OF_SERVICE_CLR = 3'h0;
    localparam logic [2:0] OP2_NS_EOI       = 3'h1;
    localparam logic [2:0] OP2_SP_EOI       = 3'h3;
    localparam logic [2:0] OP2_ROT_AUTO_END_OF_SERVICE_SET = 3'h4;
    localparam logic [2:0] OP2_ROT_NS_EOI   = 3'h5;
    localparam logic [2:0] OP2_SET_PRI      = 3'h6;
    localparam logic [2:0] OP2_ROT_SP_EOI   = 3'h7;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [2:0] LOWEST_RESET = 3'h7;
    localparam logic [1:0] ACK_PULSES   = 2'h2;

    typedef enum logic {ACK_IDLE, ACK_LOW} ackState_t;

endpackage

//--- pic_priority_pick.sv
`timescale 1ns/100ps
module pic_priority_pick (
    input  wire logic [7:0] vec,
    input  wire logic [2:0] lowest,
    output logic            found,
    output logic [2:0]      idx
);

    // Scan from lowest priority up, so the last hit is the highest
    always_comb begin
        logic [2:0] cand;
        cand  = lowest;
        found = 1'b0;
        idx   = lowest;
        for (int k = 8; k >= 1; k--) begin
            cand = lowest + k[2:0];
            if (vec[cand]) begin
                found = 1'b1;
                idx   = cand;
            end
        end
    end

endmodule

//--- pic_request_latch.sv
`timescale 1ns/100ps
module pic_request_latch
    import pic_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [7:0] requestLines,
    input  wire logic       levelMode,
    input  wire logic [7:0] clrBits,
    output logic      [7:0] pending
);

    logic [7:0] pending_q, pending_d;
    logic [7:0] prev_q, prev_d;
    logic [7:0] setBits;

    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    always_comb begin
        setBits   = levelMode ? requestLines : (requestLines & ~prev_q);
        // A new request in the clearing cycle survives the clear
        pending_d = (pending_q & ~clrBits & (levelMode ? requestLines : 8'hff)) | setBits;
        prev_d    = requestLines;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pending_q <= REG_RESET;
            prev_q    <= REG_RESET;
        end else begin
            pending_q <= pending_d;
            prev_q    <= prev_d;
        end
    end

    assign pending = pending_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_edge_capture;
        @(posedge mclk) disable iff (!resetn)
        !levelMode && |(requestLines & ~prev_q)
            |=> ((pending_q & $past(requestLines & ~prev_q)) == $past(requestLines & ~prev_q));
    endproperty
    a_edge_capture: assert property (p_edge_capture)
        else $error("Rising request edge not captured");

endmodule

//--- pic_nest_logic.sv
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
// ------------------------------------------------------------
// Contract
// - Auto rotation demotes just-serviced line to lowest
// - Auto rotation from non-specific or automatic end
// - Specific rotation sets lowest from bits 2..0
// - Automatic end clears at last acknowledge rise
// - Non-specific end clears highest in-service bit
// - Specific end clears encoded in-service bit
// - Selective mask blocks only in-service lines
// - Edge mode captures request rising edge
// - Init word one bit 3 picks trigger
// - Poll bit makes next read identity byte
// - Poll read sets in-service, bit 7 high
// - Identity byte: index 2..0, flag bit 7
// - Fully nested after clear and re-initialisation
// - Line 0 highest, line 7 lowest nested
// - Acknowledge moves best request into service
// - Lower requests blocked, higher ones still raise
// - Interrupt only for qualifying unmasked request
// ------------------------------------------------------------
module pic_nest_logic
    import pic_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrEn,
    input  wire logic       rdEn,
    output logic      [7:0] rdData,
    input  wire logic       ackStrobeN,
    input  wire logic [7:0] requestLines,
    output logic            cpuIrqLine
);

    logic       levelMode_q, levelMode_d;
    logic       autoEoi_q, autoEoi_d;
    logic       rotateAeoi_q, rotateAeoi_d;
    logic       smm_q, smm_d;
    logic       pollArm_q, pollArm_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] inService_q, inService_d;
    logic [2:0] lowest_q, lowest_d;
    logic [7:0] rdData_q, rdData_d;
    logic       irq_q, irq_d;
    ackState_t  ackState_q, ackState_d;
    logic [2:0] ackIdx_q, ackIdx_d;
    logic       ackHit_q, ackHit_d;
    logic [1:0] pulseCnt_q, pulseCnt_d;

    logic [7:0] pending;
    logic [7:0] irrClr;
    logic [7:0] isrClr;
    logic [7:0] isrSet;
    logic [7:0] eligible;
    logic       isrFound;
    logic [2:0] isrTop;
    logic       pickFound;
    logic [2:0] pickIdx;
    logic       ackRise;

    function automatic logic [2:0] rankOf(input logic [2:0] line, input logic [2:0] low);
        rankOf = line - low - 3'h1;
    endfunction

    // ------------------------------------------------------------
    // Request capture and priority resolution
    // ------------------------------------------------------------
    pic_request_latch u_latch (
        .mclk         (mclk),
        .resetn       (resetn),
        .requestLines (requestLines),
        .levelMode    (levelMode_q),
        .clrBits      (irrClr),
        .pending      (pending)
    );

    pic_priority_pick u_isr_pick (
        .vec    (inService_q),
        .lowest (lowest_q),
        .found  (isrFound),
        .idx    (isrTop)
    );

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (smm_q) begin
                eligible[i] = !inService_q[i];
            end else begin
                eligible[i] = !isrFound || (rankOf(3'(i), lowest_q) < rankOf(isrTop, lowest_q));
            end
        end
    end

    pic_priority_pick u_req_pick (
        .vec    (pending & ~mask_q & eligible),
        .lowest (lowest_q),
        .found  (pickFound),
        .idx    (pickIdx)
    );

    assign ackRise = (ackState_q == ACK_LOW) && ackStrobeN;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        levelMode_d  = levelMode_q;
        autoEoi_d    = autoEoi_q;
        rotateAeoi_d = rotateAeoi_q;
        smm_d        = smm_q;
        pollArm_d    = pollArm_q;
        mask_d       = mask_q;
        lowest_d     = lowest_q;
        ackState_d   = ackState_q;
        ackIdx_d     = ackIdx_q;
        ackHit_d     = ackHit_q;
        pulseCnt_d   = pulseCnt_q;
        rdData_d     = 8'h00;
        irrClr       = 8'h00;
        isrClr       = 8'h00;
        isrSet       = 8'h00;

        if (wrEn) begin
            case (addr)
                ADDR_INIT_ONE: begin
                    levelMode_d  = wrData[LEVEL_BIT];
                    // Re-initialisation falls back to fully nested operation
                    isrClr       = 8'hff;
                    mask_d       = REG_RESET;
                    lowest_d     = LOWEST_RESET;
                    rotateAeoi_d = 1'b0;
                    smm_d        = 1'b0;
                    pollArm_d    = 1'b0;
                    pulseCnt_d   = 2'h0;
                end
                ADDR_INIT_FOUR: begin
                    autoEoi_d = wrData[AUTO_END_OF_SERVICE_BIT];
                end
                ADDR_MASK: begin
                    mask_d = wrData;
                end
                ADDR_OPW_TWO: begin
                    case (wrData[7:5])
                        OP2_NS_EOI: begin
                            if (isrFound) begin
                                isrClr[isrTop] = 1'b1;
                            end
                        end
                        OP2_ROT_NS_EOI: begin
                            if (isrFound) begin
                                isrClr[isrTop] = 1'b1;
                                lowest_d       = isrTop;
                            end
                        end
                        OP2_SP_EOI: begin
                            isrClr[wrData[2:0]] = 1'b1;
                        end
                        OP2_ROT_SP_EOI: begin
                            isrClr[wrData[2:0]] = 1'b1;
                            lowest_d            = wrData[2:0];
                        end
                        OP2_SET_PRI: begin
                            lowest_d = wrData[2:0];
                        end
                        OP2_ROT_AUTO_END_OF_SERVICE_SET: begin
                            rotateAeoi_d = 1'b1;
                        end
                        OP2_ROT_AUTO_END_OF_SERVICE_CLR: begin
                            rotateAeoi_d = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
                ADDR_OPW_THREE: begin
                    pollArm_d = wrData[POLL_BIT];
                    if (wrData[SMM_EN_BIT]) begin
                        smm_d = wrData[SMM_VAL_BIT];
                    end
                end
                default: begin
                end
            endcase
        end

        if (rdEn) begin
            if (pollArm_q) begin
                // One armed read only; the processor re-arms before each poll
                pollArm_d = 1'b0;
                rdData_d  = {pickFound, 4'h0, pickIdx};
                if (pickFound) begin
                    isrSet[pickIdx] = 1'b1;
                    irrClr[pickIdx] = 1'b1;
                end
            end else begin
                case (addr)
                    ADDR_INIT_ONE:  rdData_d = {4'h0, levelMode_q, 3'h0};
                    ADDR_INIT_FOUR: rdData_d = {6'h00, autoEoi_q, 1'b0};
                    ADDR_MASK:      rdData_d = mask_q;
                    ADDR_OPW_TWO:   rdData_d = {4'h0, rotateAeoi_q, lowest_q};
                    ADDR_OPW_THREE: rdData_d = {1'b0, smm_q, 3'h0, pollArm_q, 2'h0};
                    ADDR_PENDING:   rdData_d = pending;
                    ADDR_INSERVICE: rdData_d = inService_q;
                    default:        rdData_d = 8'h00;
                endcase
            end
        end

        // Acknowledge sequence; level sources must hold past the first fall
        case (ackState_q)
            ACK_IDLE: begin
                if (!ackStrobeN) begin
                    ackState_d = ACK_LOW;
                    if (pulseCnt_q == 2'h0) begin
                        ackIdx_d = pickIdx;
                        ackHit_d = pickFound;
                    end
                end
            end
            ACK_LOW: begin
                if (ackStrobeN) begin
                    ackState_d = ACK_IDLE;
                    if (pulseCnt_q == 2'h0 && ackHit_q) begin
                        isrSet[ackIdx_q] = 1'b1;
                        irrClr[ackIdx_q] = 1'b1;
                    end
                    if (pulseCnt_q == ACK_PULSES - 2'h1) begin
                        pulseCnt_d = 2'h0;
                        if (autoEoi_q && isrFound) begin
                            isrClr[isrTop] = 1'b1;
                            if (rotateAeoi_q) begin
                                lowest_d = isrTop;
                            end
                        end
                    end else begin
                        pulseCnt_d = pulseCnt_q + 2'h1;
                    end
                end
            end
            default: begin
                ackState_d = ACK_IDLE;
            end
        endcase

        // Setting a line wins over clearing it in the same cycle
        inService_d = (inService_q & ~isrClr) | isrSet;
        irq_d       = pickFound;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            levelMode_q  <= 1'b0;
            autoEoi_q    <= 1'b0;
            rotateAeoi_q <= 1'b0;
            smm_q        <= 1'b0;
            pollArm_q    <= 1'b0;
            mask_q       <= REG_RESET;
            inService_q  <= REG_RESET;
            lowest_q     <= LOWEST_RESET;
            rdData_q     <= 8'h00;
            irq_q        <= 1'b0;
            ackState_q   <= ACK_IDLE;
            ackIdx_q     <= 3'h0;
            ackHit_q     <= 1'b0;
            pulseCnt_q   <= 2'h0;
        end else begin
            levelMode_q  <= levelMode_d;
            autoEoi_q    <= autoEoi_d;
            rotateAeoi_q <= rotateAeoi_d;
            smm_q        <= smm_d;
            pollArm_q    <= pollArm_d;
            mask_q       <= mask_d;
            inService_q  <= inService_d;
            lowest_q     <= lowest_d;
            rdData_q     <= rdData_d;
            irq_q        <= irq_d;
            ackState_q   <= ackState_d;
            ackIdx_q     <= ackIdx_d;
            ackHit_q     <= ackHit_d;
            pulseCnt_q   <= pulseCnt_d;
        end
    end

    assign rdData     = rdData_q;
    assign cpuIrqLine = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_op2(logic [2:0] cmd);
        wrEn && addr == ADDR_OPW_TWO && wrData[7:5] == cmd && !ackRise;
    endsequence

    sequence s_last_ack_auto_end_of_service;
        ackRise && pulseCnt_q == ACK_PULSES - 2'h1 && autoEoi_q && isrFound;
    endsequence

    sequence s_poll_arm;
        wrEn && addr == ADDR_OPW_THREE && wrData[POLL_BIT];
    endsequence

    sequence s_poll_read;
        pollArm_q && rdEn && pickFound;
    endsequence

    property p_rot_ns;
        s_op2(OP2_ROT_NS_EOI) and isrFound |=> lowest_q == $past(isrTop);
    endproperty
    a_rot_ns: assert property (p_rot_ns)
        else $error("Rotate on end did not demote serviced line");

    property p_auto_end_of_service;
        s_last_ack_auto_end_of_service and rotateAeoi_q
            |=> lowest_q == $past(isrTop) && !inService_q[$past(isrTop)];
    endproperty
    a_auto_end_of_service: assert property (p_auto_end_of_service)
        else $error("Automatic end or rotation missing at last acknowledge");

    property p_set_pri;
        s_op2(OP2_SET_PRI) |=> lowest_q == $past(wrData[2:0]);
    endproperty
    a_set_pri: assert property (p_set_pri)
        else $error("Set priority did not take encoded line");

    property p_ns_eoi;
        s_op2(OP2_NS_EOI) and isrFound && !rdEn
            |=> inService_q == ($past(inService_q) & ~(8'h01 << $past(isrTop)));
    endproperty
    a_ns_eoi: assert property (p_ns_eoi)
        else $error("Non-specific end cleared wrong bits");

    property p_sp_eoi;
        s_op2(OP2_SP_EOI) and !rdEn |=> !inService_q[$past(wrData[2:0])];
    endproperty
    a_sp_eoi: assert property (p_sp_eoi)
        else $error("Specific end left bit in service");

    property p_smm;
        smm_q && pickFound |-> !inService_q[pickIdx] && !mask_q[pickIdx];
    endproperty
    a_smm: assert property (p_smm)
        else $error("Selective mask picked served or masked line");

    property p_poll_arm;
        s_poll_arm |=> pollArm_q;
    endproperty
    a_poll_arm: assert property (p_poll_arm)
        else $error("Poll write did not arm poll read");

    property p_poll_read;
        s_poll_read |=> rdData_q[PEND_FLAG_BIT] && rdData_q[2:0] == $past(pickIdx)
            && inService_q[$past(pickIdx)] && !pollArm_q;
    endproperty
    a_poll_read: assert property (p_poll_read)
        else $error("Poll read identity or in-service wrong");

    property p_nested;
        lowest_q == LOWEST_RESET && !smm_q && !isrFound && pending[0] && !mask_q[0]
            |-> pickFound && pickIdx == 3'h0;
    endproperty
    a_nested: assert property (p_nested)
        else $error("Line 0 not highest in nested order");

    property p_ack_set;
        ackRise && pulseCnt_q == 2'h0 && ackHit_q |=> inService_q[$past(ackIdx_q)];
    endproperty
    a_ack_set: assert property (p_ack_set)
        else $error("Acknowledge did not set in-service bit");

    property p_nest_block;
        !smm_q && isrFound && pickFound |-> rankOf(pickIdx, lowest_q) < rankOf(isrTop, lowest_q);
    endproperty
    a_nest_block: assert property (p_nest_block)
        else $error("Lower priority request passed nesting");

    property p_irq;
        pickFound ##1 pickFound |-> cpuIrqLine;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt line not following qualifying request");

endmodule

//--- cpu_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Processor side of the register port
// ----------------------------------------
module cpu_model
    import pic_pkg::*;
(
    input  wire logic       mclk,
    output logic      [2:0] addr,
    output logic      [7:0] wrData,
    output logic            wrEn,
    output logic            rdEn,
    input  wire logic [7:0] rdData,
    output logic            ackStrobeN
);
    initial begin
        addr = 3'h0;
        wrData = 8'h00;
        wrEn = 1'b0;
        rdEn = 1'b0;
        ackStrobeN = 1'b1;
    end

    // Idle address and data are inverted so a stale value never looks valid
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge mclk);
        wrEn <= 1'b0;
        addr <= ~a;
        wrData <= ~d;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge mclk);
        rdEn <= 1'b0;
        addr <= ~a;
        #1 d = rdData;
    endtask

    // Interrupt line is not consulted while polling
    task automatic poll(input logic [2:0] a, output logic [7:0] d);
        wr(ADDR_OPW_THREE, 8'h04);
        rd(a, d);
        if (d[7] !== 1'b1) d[2:0] = 3'h0;
    endtask

    // Two pulses form one sequence
    task automatic ackSeq();
        repeat (2) begin
            @(posedge mclk);
            ackStrobeN <= 1'b0;
            @(posedge mclk);
            ackStrobeN <= 1'b1;
            @(posedge mclk);
        end
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/100ps
module testbench
    import pic_pkg::*;
;
    logic       mclk = 1'b0;
    logic       resetn = 1'b0;
    logic [7:0] requestLines = 8'h00;
    logic [7:0] rdData, wrData, seen;
    logic [2:0] addr;
    logic       cpuIrqLine, wrEn, rdEn, ackStrobeN;
    int         errCount = 0;
    int         comparisons = 0;
    int         cycles = 0;

    always #4 mclk = ~mclk;

    pic_nest_logic dut_u (.mclk(mclk), .resetn(resetn), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .ackStrobeN(ackStrobeN),
        .requestLines(requestLines), .cpuIrqLine(cpuIrqLine));
    cpu_model cpu_u (.mclk(mclk), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData(rdData), .ackStrobeN(ackStrobeN));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic giveVerdict();
        $display("mismatches %0d, comparisons %0d", errCount, comparisons);
        if (errCount == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Run is short; a stuck scenario is cut off well past its expected length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            giveVerdict();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
        cpu_u.rd(a, seen);
        check(seen, exp);
    endtask

    task automatic irqChk(input logic exp);
        repeat (2) @(posedge mclk);
        #1 check({7'h0, cpuIrqLine}, {7'h0, exp});
    endtask

    task automatic req(input logic [7:0] v);
        @(posedge mclk);
        requestLines <= v;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic resetValues();
        rdChk(ADDR_MASK, REG_RESET);
        rdChk(ADDR_PENDING, REG_RESET);
        rdChk(ADDR_INSERVICE, REG_RESET);
        rdChk(ADDR_OPW_TWO, {5'h0, LOWEST_RESET});
        rdChk(3'h7, 8'h00);
        irqChk(1'b0);
    endtask

    task automatic nestedOrder();
        req(8'h28);
        irqChk(1'b1);
        rdChk(ADDR_PENDING, 8'h28);
        cpu_u.ackSeq();
        rdChk(ADDR_INSERVICE, 8'h08);
        rdChk(ADDR_PENDING, 8'h20);
        irqChk(1'b0);
        req(8'h2a);
        irqChk(1'b1);
        cpu_u.ackSeq();
        rdChk(ADDR_INSERVICE, 8'h0a);
        cpu_u.wr(ADDR_OPW_TWO, {OP2_NS_EOI, 5'h0});
        rdChk(ADDR_INSERVICE, 8'h08);
        cpu_u.wr(ADDR_OPW_TWO, {OP2_SP_EOI, 5'h3});
        rdChk(ADDR_INSERVICE, 8'h00);
        irqChk(1'b1);
        cpu_u.wr(ADDR_MASK, 8'h20);
        irqChk(1'b0);
        cpu_u.wr(ADDR_MASK, 8'h00);
        req(8'h00);
    endtask

    task automatic autoRotate();
        cpu_u.wr(ADDR_INIT_FOUR, 8'h02);
        cpu_u.wr(ADDR_OPW_TWO, {OP2_ROT_AUTO_END_OF_SERVICE_SET, 5'h0});
        cpu_u.ackSeq();
        rdChk(ADDR_INSERVICE, 8'h00);
        rdChk(ADDR_OPW_TWO, 8'h0d);
        req(8'h60);
        cpu_u.ackSeq();
        rdChk(ADDR_PENDING, 8'h20);
        rdChk(ADDR_OPW_TWO, 8'h0e);
        cpu_u.wr(ADDR_INIT_FOUR, 8'h00);
        cpu_u.wr(ADDR_OPW_TWO, {OP2_ROT_AUTO_END_OF_SERVICE_CLR, 5'h0});
        cpu_u.ackSeq();
        rdChk(ADDR_INSERVICE, 8'h20);
        cpu_u.wr(ADDR_OPW_TWO, {OP2_ROT_NS_EOI, 5'h0});
        rdChk(ADDR_INSERVICE, 8'h00);
        rdChk(ADDR_OPW_TWO, 8'h05);
        req(8'h00);
    endtask

    task automatic specificRotate();
        logic [7:0] cmd [4] = '{{OP2_SET_PRI, 5'h2}, 8'h40, {OP2_ROT_SP_EOI, 5'h4},
                                {OP2_ROT_AUTO_END_OF_SERVICE_SET, 5'h0}};
        logic [7:0] exp [4] = '{8'h02, 8'h02, 8'h04, 8'h0c};
        for (int i = 0; i < 4; i++) begin
            cpu_u.wr(ADDR_OPW_TWO, cmd[i]);
            rdChk(ADDR_OPW_TWO, exp[i]);
        end
        cpu_u.wr(ADDR_INIT_ONE, 8'h00);
        rdChk(ADDR_OPW_TWO, 8'h07);
    endtask

    task automatic levelMode();
        cpu_u.wr(ADDR_INIT_ONE, 8'h08);
        rdChk(ADDR_INIT_ONE, 8'h08);
        req(8'h10);
        rdChk(ADDR_PENDING, 8'h10);
        req(8'h00);
        rdChk(ADDR_PENDING, 8'h00);
        req(8'h04);
        irqChk(1'b1);
        cpu_u.ackSeq();
        req(8'h00);
        rdChk(ADDR_INSERVICE, 8'h04);
        cpu_u.wr(ADDR_INIT_ONE, 8'h00);
    endtask

    task automatic selectiveMask();
        cpu_u.wr(ADDR_OPW_THREE, 8'h60);
        rdChk(ADDR_OPW_THREE, 8'h40);
        req(8'h04);
        cpu_u.ackSeq();
        rdChk(ADDR_INSERVICE, 8'h04);
        req(8'h44);
        irqChk(1'b1);
        cpu_u.wr(ADDR_MASK, 8'h40);
        irqChk(1'b0);
        cpu_u.wr(ADDR_MASK, 8'h00);
        cpu_u.wr(ADDR_OPW_THREE, 8'h40);
        irqChk(1'b0);
        req(8'h00);
        cpu_u.wr(ADDR_INIT_ONE, 8'h00);
    endtask

    // Bits 6..3 of the identity byte carry no meaning and are masked off
    task automatic pollRead();
        cpu_u.poll(ADDR_MASK, seen);
        check(seen & 8'h87, 8'h86);
        rdChk(ADDR_INSERVICE, 8'h40);
        rdChk(ADDR_PENDING, 8'h00);
        cpu_u.poll(ADDR_PENDING, seen);
        check(seen & 8'h87, 8'h00);
        rdChk(ADDR_MASK, 8'h00);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        resetValues();
        nestedOrder();
        autoRotate();
        specificRotate();
        levelMode();
        selectiveMask();
        pollRead();
        giveVerdict();
    end
endmodule
